// >>> core/pmc_pkg.sv
package pmc_pkg;

  localparam int NPRM = 17;
  localparam int SLOT_W = 5;

  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
  localparam logic [15:0] VOUT_FORMAT_VAL = 16'h0014;
  localparam logic [15:0] UNMAPPED_VAL = 16'hffff;

  localparam int SL_OPER = 0;
  localparam int SL_ONOFF = 1;
  localparam int SL_VOUT = 2;
  localparam int SL_FREQ = 3;
  localparam int SL_OVF = 4;
  localparam int SL_OVRSP = 5;
  localparam int SL_OVW = 6;
  localparam int SL_OCF = 7;
  localparam int SL_OCRSP = 8;
  localparam int SL_OCW = 9;
  localparam int SL_OTF = 10;
  localparam int SL_OTRSP = 11;
  localparam int SL_OTW = 12;
  localparam int SL_VINOV = 13;
  localparam int SL_PGON = 14;
  localparam int SL_PGOFF = 15;
  localparam int SL_TON = 16;

  // Slot order matches the SL_ constants above.
  localparam logic [7:0] PRM_CODE [NPRM] = '{8'h01, 8'h02, 8'h21, 8'h33, 8'h40, 8'h41,
    8'h42, 8'h46, 8'h47, 8'h4a, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h5e, 8'h5f, 8'h60};
  localparam logic PRM_WORD [NPRM] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
    1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic [15:0] PRM_DEF [NPRM] = '{16'h0080, 16'h001d, 16'hc000, 16'hf208,
    16'hf000, 16'h00b8, 16'hf000, 16'he3c0, 16'h00f8, 16'he320, 16'hf1f4, 16'h00b8,
    16'hf1cc, 16'heb70, 16'hb000, 16'h9000, 16'hf814};
  // Limits are whole coded words; a wrong exponent field falls outside them.
  localparam logic [15:0] PRM_MIN [NPRM] = '{16'h0000, 16'h0000, 16'h999a, 16'hf1e0,
    16'hb000, 16'h0000, 16'hb000, 16'he1e0, 16'h0000, 16'he1e0, 16'hf064, 16'h0000,
    16'hf064, 16'he980, 16'h819a, 16'h819a, 16'hf80a};
  localparam logic [15:0] PRM_MAX [NPRM] = '{16'h00ff, 16'h00ff, 16'hd333, 16'hf230,
    16'hffff, 16'h00ff, 16'hffff, 16'he3ff, 16'h00ff, 16'he3ff, 16'hf230, 16'h00ff,
    16'hf1f4, 16'heb70, 16'hd333, 16'hd333, 16'hfbe8};
  localparam logic [15:0] ONOFF_POS_DEF = 16'h001f;
  localparam logic [15:0] PG_MARGIN = 16'h199a;

  localparam int OPER_ON_BIT = 7;
  localparam int ONOFF_GATED_BIT = 4;
  localparam int ONOFF_CMD_BIT = 3;
  localparam int ONOFF_PIN_BIT = 2;
  localparam int ONOFF_POL_BIT = 1;

  typedef logic [15:0] pmc_prm_t [NPRM];

  typedef struct packed {
    logic vin_ov;
    logic temp_over;
    logic iout_oc;
    logic vout_ov;
  } pmc_fault_t;

  typedef struct packed {
    logic comm;
    pmc_fault_t flt;
  } pmc_status_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_SKIP} pmc_state_t;

endpackage

// >>> core/pmc_cmd_slave.sv
`timescale 1ns/100ps
module pmc_cmd_slave #(
  parameter bit POS_LOGIC_PART = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [6:0] bus_addr_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic onoff_pin_i,
  input wire logic [15:0] vout_meas_i,
  input wire pmc_pkg::pmc_fault_t fault_evt_i,
  output pmc_pkg::pmc_status_t fault_status_o,
  output logic out_enable_o,
  output logic power_good_o,
  output logic [15:0] vout_setpoint_o
);
  import pmc_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  // Returns {hit, slot} for a stored parameter code.
  function automatic logic [SLOT_W:0] slot_of(input logic [7:0] code);
    logic [SLOT_W:0] res;
    res = '0;
    for (int i = 0; i < NPRM; i++) begin
      if (PRM_CODE[i] == code) begin
        res = {1'b1, SLOT_W'(i)};
      end
    end
    return res;
  endfunction

  // Checks every limit and every ordering between limits on a candidate set.
  function automatic logic set_ok(input pmc_prm_t p);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NPRM; i++) begin
      if (p[i] < PRM_MIN[i] || p[i] > PRM_MAX[i]) begin
        ok = 1'b0;
      end
    end
    if (p[SL_OVF] <= p[SL_VOUT] || p[SL_OVF] <= p[SL_OVW]) begin
      ok = 1'b0;
    end
    if (p[SL_OCF] <= p[SL_OCW]) begin
      ok = 1'b0;
    end
    if (p[SL_OTF] <= p[SL_OTW]) begin
      ok = 1'b0;
    end
    if ({1'b0, p[SL_PGON]} < {1'b0, p[SL_PGOFF]} + {1'b0, PG_MARGIN}) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers and link state
  // ----------------------------------------------------------------------
  logic [2:0] scl_sync_reg, scl_sync_next;
  logic [2:0] sda_sync_reg, sda_sync_next;
  logic [2:0] pin_sync_reg, pin_sync_next;
  logic scl_f_reg, scl_f_next;
  logic sda_f_reg, sda_f_next;
  logic pin_f_reg, pin_f_next;
  logic [6:0] addr_reg, addr_next;
  logic addr_ld_reg, addr_ld_next;
  pmc_state_t state_reg, state_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [1:0] wcnt_reg, wcnt_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] rdat_reg, rdat_next;
  logic [1:0] rbi_reg, rbi_next;
  logic mack_reg, mack_next;
  logic drive_low_reg, drive_low_next;
  logic exec_go;
  logic rd_miss;

  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] tx_byte;
  logic [SLOT_W:0] rd_slot;

  pmc_prm_t prm_reg, prm_next;

  assign scl_rise = scl_f_next & ~scl_f_reg;
  assign scl_fall = ~scl_f_next & scl_f_reg;
  assign bus_start = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
  assign bus_stop = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
  assign tx_byte = (rbi_reg == 2'd0) ? rdat_reg[7:0] :
                   (rbi_reg == 2'd1) ? rdat_reg[15:8] : 8'hff;
  assign rd_slot = slot_of(cmd_reg);

  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], scl_i};
    sda_sync_next = {sda_sync_reg[1:0], sda_i};
    pin_sync_next = {pin_sync_reg[1:0], onoff_pin_i};
    // A change counts once the second and third stages agree.
    scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    pin_f_next = (pin_sync_reg[1] == pin_sync_reg[2]) ? pin_sync_reg[2] : pin_f_reg;
    addr_ld_next = 1'b1;
    addr_next = addr_ld_reg ? addr_reg : bus_addr_i;
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    wcnt_next = wcnt_reg;
    wdata_next = wdata_reg;
    rdat_next = rdat_reg;
    rbi_next = rbi_reg;
    mack_next = mack_reg;
    drive_low_next = drive_low_reg;
    exec_go = 1'b0;
    rd_miss = 1'b0;
    if (bus_start) begin
      // Also a repeated start: a pending write is dropped, not executed.
      state_next = ST_ADDR;
      bitcnt_next = 4'd0;
      rbi_next = 2'd0;
      drive_low_next = 1'b0;
    end else if (bus_stop) begin
      exec_go = (state_reg == ST_WDATA);
      state_next = ST_IDLE;
      drive_low_next = 1'b0;
    end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
      if (scl_rise) begin
        if (bitcnt_reg < 4'd8) begin
          shift_next = {shift_reg[6:0], sda_f_reg};
          bitcnt_next = bitcnt_reg + 4'd1;
        end else begin
          bitcnt_next = 4'd9;
          mack_next = ~sda_f_reg;
        end
      end else if (scl_fall) begin
        if (bitcnt_reg == 4'd8) begin
          drive_low_next = 1'b1;
          unique case (state_reg)
            ST_ADDR: begin
              if (shift_reg[7:1] == addr_reg) begin
                if (shift_reg[0]) begin
                  state_next = ST_RDATA;
                  mack_next = 1'b1;
                  if (cmd_reg == CMD_VOUT_FORMAT) begin
                    rdat_next = VOUT_FORMAT_VAL;
                  end else if (rd_slot[SLOT_W]) begin
                    rdat_next = prm_reg[rd_slot[SLOT_W-1:0]];
                  end else begin
                    rdat_next = UNMAPPED_VAL;
                    rd_miss = 1'b1;
                  end
                end else begin
                  state_next = ST_CMD;
                end
              end else begin
                state_next = ST_SKIP;
                drive_low_next = 1'b0;
              end
            end
            ST_CMD: begin
              cmd_next = shift_reg;
              wcnt_next = 2'd0;
              state_next = ST_WDATA;
            end
            ST_WDATA: begin
              if (wcnt_reg == 2'd0) begin
                wdata_next[7:0] = shift_reg;
              end else begin
                wdata_next[15:8] = shift_reg;
              end
              if (wcnt_reg != 2'd3) begin
                wcnt_next = wcnt_reg + 2'd1;
              end
            end
            ST_RDATA: begin
              // The master owns the acknowledge bit of a read byte.
              drive_low_next = 1'b0;
              rbi_next = (rbi_reg == 2'd2) ? rbi_reg : rbi_reg + 2'd1;
            end
            default: begin
              drive_low_next = 1'b0;
            end
          endcase
        end else if (bitcnt_reg == 4'd9) begin
          bitcnt_next = 4'd0;
          drive_low_next = 1'b0;
          if (state_reg == ST_RDATA) begin
            if (mack_reg) begin
              drive_low_next = ~tx_byte[7];
            end else begin
              state_next = ST_SKIP;
            end
          end
        end else if (state_reg == ST_RDATA) begin
          drive_low_next = ~tx_byte[3'd7 - bitcnt_reg[2:0]];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      pin_sync_reg <= 3'h0;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      pin_f_reg <= 1'b0;
      addr_reg <= 7'h00;
      addr_ld_reg <= 1'b0;
      state_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      wcnt_reg <= 2'h0;
      wdata_reg <= 16'h0000;
      rdat_reg <= 16'h0000;
      rbi_reg <= 2'h0;
      mack_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      pin_sync_reg <= pin_sync_next;
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      pin_f_reg <= pin_f_next;
      addr_reg <= addr_next;
      addr_ld_reg <= addr_ld_next;
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      wcnt_reg <= wcnt_next;
      wdata_reg <= wdata_next;
      rdat_reg <= rdat_next;
      rbi_reg <= rbi_next;
      mack_reg <= mack_next;
      drive_low_reg <= drive_low_next;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drive_low_reg;

  // ----------------------------------------------------------------------
  // Parameter store, command execution and converter control
  // ----------------------------------------------------------------------
  // The nonvolatile copy is modelled by registers that start at the defaults.
  pmc_prm_t nvm_reg, nvm_next;
  pmc_status_t status_reg, status_next;
  logic pg_reg, pg_next;
  logic on_reg, on_next;
  logic [SLOT_W:0] wr_slot;
  logic [4:0] evt_bits;

  assign wr_slot = slot_of(cmd_reg);

  always_comb begin
    pmc_prm_t cand;
    logic bad_cmd;
    logic clr;
    logic pin_on;
    cand = prm_reg;
    pin_on = 1'b0;
    bad_cmd = rd_miss;
    clr = 1'b0;
    prm_next = prm_reg;
    nvm_next = nvm_reg;
    if (exec_go) begin
      if (wcnt_reg == 2'd0) begin
        if (cmd_reg == CMD_CLEAR_FAULTS) begin
          clr = 1'b1;
        end else if (cmd_reg == CMD_STORE_ALL) begin
          nvm_next = prm_reg;
        end else if (cmd_reg == CMD_RESTORE_ALL) begin
          prm_next = nvm_reg;
        end else begin
          bad_cmd = 1'b1;
        end
      end else if (wr_slot[SLOT_W] && wcnt_reg == (PRM_WORD[wr_slot[SLOT_W-1:0]] ? 2'd2 : 2'd1)) begin
        cand[wr_slot[SLOT_W-1:0]] = PRM_WORD[wr_slot[SLOT_W-1:0]] ?
          wdata_reg : {8'h00, wdata_reg[7:0]};
        if (set_ok(cand)) begin
          prm_next = cand;
        end else begin
          bad_cmd = 1'b1;
        end
      end else begin
        bad_cmd = 1'b1;
      end
    end
    // A fault arriving with the clear command stays set.
    evt_bits = {bad_cmd, fault_evt_i};
    status_next = pmc_status_t'((clr ? 5'h00 : 5'(status_reg)) | evt_bits);
    // Hysteresis between the two power-good levels.
    pg_next = pg_reg ? (vout_meas_i >= prm_reg[SL_PGOFF])
                     : (vout_meas_i >= prm_reg[SL_PGON]);
    pin_on = prm_reg[SL_ONOFF][ONOFF_POL_BIT] ? pin_f_reg : ~pin_f_reg;
    on_next = ~prm_reg[SL_ONOFF][ONOFF_GATED_BIT] |
              ((~prm_reg[SL_ONOFF][ONOFF_CMD_BIT] | prm_reg[SL_OPER][OPER_ON_BIT]) &
               (~prm_reg[SL_ONOFF][ONOFF_PIN_BIT] | pin_on));
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NPRM; i++) begin
        prm_reg[i] <= (i == SL_ONOFF && POS_LOGIC_PART) ? ONOFF_POS_DEF : PRM_DEF[i];
        nvm_reg[i] <= (i == SL_ONOFF && POS_LOGIC_PART) ? ONOFF_POS_DEF : PRM_DEF[i];
      end
      status_reg <= '0;
      pg_reg <= 1'b0;
      on_reg <= 1'b0;
    end else begin
      prm_reg <= prm_next;
      nvm_reg <= nvm_next;
      status_reg <= status_next;
      pg_reg <= pg_next;
      on_reg <= on_next;
    end
  end

  assign fault_status_o = status_reg;
  assign power_good_o = pg_reg;
  assign out_enable_o = on_reg;
  assign vout_setpoint_o = prm_reg[SL_VOUT];

endmodule // pmc_cmd_slave

// >>> sim/pmc_cmd_slave_properties.sv
`timescale 1ns/100ps
module pmc_cmd_slave_properties (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [6:0] bus_addr_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic onoff_pin_i,
  input wire logic [15:0] vout_meas_i,
  input wire pmc_pkg::pmc_fault_t fault_evt_i,
  input wire pmc_pkg::pmc_status_t fault_status_o,
  input wire logic out_enable_o,
  input wire logic power_good_o,
  input wire logic [15:0] vout_setpoint_o
);
  import pmc_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // ----
  // Bus stop tracking
  // ----
  // Writes and clears act only at a STOP, so anything moving long after one is a fault.
  logic sda_last_reg;
  logic [7:0] since_stop_reg;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sda_last_reg <= 1'b1;
      since_stop_reg <= 8'hff;
    end else begin
      sda_last_reg <= sda_i;
      if (scl_i && sda_i && !sda_last_reg) begin
        since_stop_reg <= 8'h00;
      end else if (since_stop_reg != 8'hff) begin
        since_stop_reg <= since_stop_reg + 8'h01;
      end
    end
  end
  property p_pg_high;
    vout_meas_i >= 16'hd333 |=> power_good_o;
  endproperty
  a_pg_high: assert property (p_pg_high)
    else $error("power good low above every on level");
  property p_pg_low;
    vout_meas_i < 16'h819a |=> !power_good_o;
  endproperty
  a_pg_low: assert property (p_pg_low)
    else $error("power good high below every off level");
  property p_pg_rise;
    $rose(power_good_o) |-> $past(vout_meas_i) >= 16'h9b34;
  endproperty
  a_pg_rise: assert property (p_pg_rise)
    else $error("power good rose below lowest on level");
  property p_pg_fall;
    $fell(power_good_o) |-> $past(vout_meas_i) < 16'hb999;
  endproperty
  a_pg_fall: assert property (p_pg_fall)
    else $error("power good fell above highest off level");
  property p_flt_set;
    fault_evt_i != 4'h0 |=> (fault_status_o.flt & $past(fault_evt_i)) == $past(fault_evt_i);
  endproperty
  a_flt_set: assert property (p_flt_set)
    else $error("fault flag not set after its event");
  property p_flt_cause;
    (fault_status_o.flt & ~$past(fault_status_o.flt) & ~$past(fault_evt_i)) == 4'h0;
  endproperty
  a_flt_cause: assert property (p_flt_cause)
    else $error("fault flag set without an event");
  property p_flt_clear;
    (~fault_status_o.flt & $past(fault_status_o.flt)) != 4'h0 |-> since_stop_reg <= 8'h0c;
  endproperty
  a_flt_clear: assert property (p_flt_clear)
    else $error("fault flag cleared away from a stop");
  property p_sp_range;
    vout_setpoint_o >= 16'h999a && vout_setpoint_o <= 16'hd333;
  endproperty
  a_sp_range: assert property (p_sp_range)
    else $error("setpoint outside its limits");
  property p_sp_at_stop;
    $changed(vout_setpoint_o) |-> since_stop_reg <= 8'h0c;
  endproperty
  a_sp_at_stop: assert property (p_sp_at_stop)
    else $error("setpoint moved away from a stop");
  c_pg_rise: cover property ($rose(power_good_o));
  c_comm_clear: cover property ($fell(fault_status_o.comm));
  c_sp_move: cover property ($changed(vout_setpoint_o));
endmodule // pmc_cmd_slave_properties

bind pmc_cmd_slave pmc_cmd_slave_properties i_pmc_cmd_slave_properties (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .bus_addr_i(bus_addr_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o),
  .onoff_pin_i(onoff_pin_i),
  .vout_meas_i(vout_meas_i),
  .fault_evt_i(fault_evt_i),
  .fault_status_o(fault_status_o),
  .out_enable_o(out_enable_o),
  .power_good_o(power_good_o),
  .vout_setpoint_o(vout_setpoint_o)
);

// >>> sim/pmc_host_model.sv
`timescale 1ns/100ps
module pmc_host_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ----
  // Bus master
  // ----
  // SCL phases stay at nine clocks or more, above the slave's minimum half period.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bit1(input logic b, output logic r);
    sda_o <= b;
    wt(4);
    scl_o <= 1'b1;
    wt(9);
    r = sda_i;
    scl_o <= 1'b0;
    wt(5);
  endtask
  task automatic byte1(input logic [7:0] o, input logic m, output logic [7:0] i,
      output logic ak);
    for (int k = 7; k >= 0; k--) begin
      bit1(o[k], i[k]);
    end
    bit1(m, ak);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    wt(4);
    scl_o <= 1'b1;
    wt(9);
    sda_o <= 1'b0;
    wt(9);
    scl_o <= 1'b0;
    wt(5);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    wt(4);
    scl_o <= 1'b1;
    wt(9);
    sda_o <= 1'b1;
    wt(9);
  endtask
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input int nw,
      input logic [15:0] d, input int nr, output logic [15:0] q, output logic nak);
    logic [7:0] i;
    logic ak;
    q = 16'h0000;
    start();
    byte1({a, 1'b0}, 1'b1, i, nak);
    byte1(c, 1'b1, i, ak);
    nak = nak | ak;
    for (int k = 0; k < nw; k++) begin
      byte1(d[8*k +: 8], 1'b1, i, ak);
      nak = nak | ak;
    end
    if (nr > 0) begin
      start();
      byte1({a, 1'b1}, 1'b1, i, ak);
      nak = nak | ak;
      for (int k = 0; k < nr; k++) begin
        byte1(8'hff, k == nr - 1, i, ak);
        q[8*k +: 8] = i;
      end
    end
    stop();
  endtask
endmodule // pmc_host_model

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
  import pmc_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a;
  typedef struct packed {
    logic w;
    logic [7:0] c;
    logic [15:0] d;
    logic [15:0] e;
  } pmc_row_t;
  // ----
  // Rows: write flag, code, data written, value read back
  // ----
  pmc_row_t rows [35] = '{
    '{1'b0,8'h01,16'h0,16'h0080},
    '{1'b0,8'h02,16'h0,16'h001d},
    '{1'b0,8'h20,16'h0,16'h0014},
    '{1'b0,8'h21,16'h0,16'hc000},
    '{1'b0,8'h33,16'h0,16'hf208},
    '{1'b0,8'h40,16'h0,16'hf000},
    '{1'b0,8'h41,16'h0,16'h00b8},
    '{1'b0,8'h42,16'h0,16'hf000},
    '{1'b0,8'h46,16'h0,16'he3c0},
    '{1'b0,8'h47,16'h0,16'h00f8},
    '{1'b0,8'h4f,16'h0,16'hf1f4},
    '{1'b0,8'h50,16'h0,16'h00b8},
    '{1'b0,8'h51,16'h0,16'hf1cc},
    '{1'b0,8'h55,16'h0,16'heb70},
    '{1'b0,8'h5e,16'h0,16'hb000},
    '{1'b0,8'h5f,16'h0,16'h9000},
    '{1'b1,8'h42,16'he000,16'he000},
    '{1'b1,8'h01,16'h0000,16'h0000},
    '{1'b1,8'h33,16'hf1e0,16'hf1e0},
    '{1'b1,8'h21,16'hb333,16'hb333},
    '{1'b1,8'h21,16'h9999,16'hb333},
    '{1'b1,8'h21,16'hd334,16'hb333},
    '{1'b1,8'h42,16'hf000,16'he000},
    '{1'b1,8'h40,16'hb000,16'hf000},
    '{1'b1,8'h46,16'he1e0,16'he3c0},
    '{1'b1,8'h4a,16'he1e0,16'he1e0},
    '{1'b1,8'h51,16'hf1f4,16'hf1cc},
    '{1'b1,8'h55,16'hf180,16'heb70},
    '{1'b1,8'h60,16'hf80a,16'hf80a},
    '{1'b1,8'h60,16'hf809,16'hf80a},
    '{1'b1,8'h5f,16'ha000,16'h9000},
    '{1'b1,8'h47,16'h003c,16'h003c},
    '{1'b1,8'h20,16'h0055,16'h0014},
    '{1'b1,8'h99,16'h0012,16'hffff},
    '{1'b1,8'h02,16'h001f,16'h001f}
  };
  logic [15:0] pv [6] = '{16'h8000, 16'hb000, 16'h9000, 16'h8fff, 16'hafff, 16'hd333};
  logic pe [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic onoff_pin = 1'b0;
  logic [15:0] vout_meas = 16'h0000;
  pmc_fault_t fault_evt = 4'h0;
  logic h_scl;
  logic h_sda;
  logic sda_dev;
  logic sda_oe_n;
  pmc_status_t status;
  logic out_en;
  logic pg;
  logic [15:0] setpoint;
  logic [15:0] q;
  logic nak;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  // Open-drain line with a pull-up: low when either party pulls.
  wire sda = h_sda & (sda_oe_n | sda_dev);
  always #5 ref_clk = ~ref_clk;
  pmc_cmd_slave i_pmc_cmd_slave (.ref_clk_i(ref_clk), .rstn_i(rstn), .bus_addr_i(ADDR),
    .scl_i(h_scl), .sda_i(sda), .sda_o(sda_dev), .sda_oe_n_o(sda_oe_n),
    .onoff_pin_i(onoff_pin), .vout_meas_i(vout_meas), .fault_evt_i(fault_evt),
    .fault_status_o(status), .out_enable_o(out_en), .power_good_o(pg),
    .vout_setpoint_o(setpoint));
  pmc_host_model i_pmc_host_model (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(h_scl),
    .sda_o(h_sda));
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails = fails + 1;
      results();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
    i_pmc_host_model.xfer(ADDR, c, n, d, 0, q, nak);
  endtask
  task automatic rd(input logic [7:0] c);
    i_pmc_host_model.xfer(ADDR, c, 0, 16'h0000, 2, q, nak);
  endtask
  initial begin
    wt(20);
    chk(setpoint, 16'hc000, "setpoint in reset");
    chk({11'h0, status}, 16'h0000, "status in reset");
    rstn <= 1'b1;
    wt(10);
    chk({15'h0, out_en}, 16'h0001, "enable, pin active low");
    onoff_pin <= 1'b1;
    wt(8);
    chk({15'h0, out_en}, 16'h0000, "enable, pin inactive");
    $display("reset and on/off defaults done");
    foreach (rows[k]) begin
      if (rows[k].w) begin
        wr(rows[k].c, (rows[k].d[15:8] != 8'h00) ? 2 : 1, rows[k].d);
      end
      rd(rows[k].c);
      chk(q, rows[k].e, "register readback");
      chk({15'h0, nak}, 16'h0000, "bytes acknowledged");
    end
    $display("register rows done");
    wr(8'h01, 1, 16'h0080);
    wt(8);
    chk({15'h0, out_en}, 16'h0001, "enable, positive pin");
    wr(8'h01, 1, 16'h0000);
    wt(8);
    chk({15'h0, out_en}, 16'h0000, "enable, control off");
    $display("on/off control done");
    wr(8'h11, 0, 16'h0000);
    wr(8'h21, 2, 16'ha000);
    chk(setpoint, 16'ha000, "setpoint port");
    wr(8'h12, 0, 16'h0000);
    rd(8'h21);
    chk(q, 16'hb333, "restored setpoint");
    chk(setpoint, 16'hb333, "restored setpoint port");
    $display("store and restore done");
    fault_evt <= 4'h5;
    wt(1);
    fault_evt <= 4'h0;
    wt(3);
    chk({11'h0, status}, 16'h0015, "flags after first events");
    fault_evt <= 4'ha;
    wt(1);
    fault_evt <= 4'h0;
    wt(3);
    chk({11'h0, status}, 16'h001f, "flags after second events");
    wr(8'h03, 0, 16'h0000);
    wt(4);
    chk({11'h0, status}, 16'h0000, "flags after clear");
    $display("fault flags done");
    for (int k = 0; k < 6; k++) begin
      vout_meas <= pv[k];
      wt(3);
      chk({15'h0, pg}, {15'h0, pe[k]}, "power good");
    end
    $display("power good done");
    results();
  end
endmodule // tb
